/* File: prhb_pkg.sv */
// Constants and types shared by the pixel region hit buffer core, its checker and its test models.
// Assumes a single 250 MHz core clock; the bunch crossing clock arrives as a pin.
package prhb_pkg;

    // Core geometry
    localparam int PRHB_NPIX      = 64;
    localparam int PRHB_NREG      = 16;
    localparam int PRHB_RPIX      = 4;
    localparam int PRHB_NTIM      = 8;
    localparam int PRHB_TIM_IDX_W = 3;
    localparam int PRHB_REG_IDX_W = 4;
    localparam int PRHB_SLOT_W    = 7;

    // Pulse width storage
    localparam int PRHB_WID_W = 4;
    localparam logic [3:0] PRHB_WID_MAX  = 4'hF;
    localparam logic [3:0] PRHB_WID_ONE  = 4'h1;
    localparam logic [3:0] PRHB_WID_RST  = 4'h0;

    // Latency timers and trigger tags
    localparam int PRHB_LAT_W = 9;
    localparam logic [8:0] PRHB_LAT_RST = 9'h000;
    localparam logic [8:0] PRHB_LAT_ONE = 9'h001;
    localparam int PRHB_TAG_W = 5;
    localparam logic [4:0] PRHB_TAG_RST = 5'h00;

    // Readout record: region index, tag, four pixel widths
    localparam int PRHB_REC_W = PRHB_REG_IDX_W + PRHB_TAG_W + PRHB_RPIX * PRHB_WID_W;
    localparam int PRHB_FIFO_DEPTH = 16;

    // Timing alignment step: longest skew rounded down, at least one cycle
    localparam int PRHB_CLK_MHZ  = 250;
    localparam int PRHB_SKEW_NS  = 2;
    localparam int PRHB_SKEW_RAW = (PRHB_SKEW_NS * PRHB_CLK_MHZ) / 1000;
    localparam int PRHB_SKEW_CYC = (PRHB_SKEW_RAW < 1) ? 1 : PRHB_SKEW_RAW;

    // Synchronised input bundle width
    localparam int PRHB_SYNC_W = PRHB_NPIX + 5 + 2 * PRHB_TAG_W;

    typedef enum logic [1:0] {
        PRHB_RD_IDLE,
        PRHB_RD_SCAN,
        PRHB_RD_PASS
    } prhb_rd_state_type;

endpackage

/* File: prhb_fifo.sv */
// Readout FIFO of flip-flops, parameterised in width and depth.
// Assumes both sides run on core_clk_i; valid/ready handshake on each side.
`timescale 1ns/1ps
module prhb_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != FULL_CNT);
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

/* File: prhb_core.sv */
// Digital pixel core: 64 pixels in 16 regions of four, pulse width counting,
// shared region latency timers, trigger tagging and token chain readout.
// Assumes pins arrive asynchronously to core_clk_i; readout data sink is synchronous.
//
// Notes on behaviour
// - One core serves 8x8 pixels, drives island config, takes four outputs per island.
// - Global inputs except the token, plus island config, re-driven upward; clock and injection delayed internally for alignment.
// - Bunch clock and injection each gated off per column, independently.
// - Sixteen identical regions of four pixels, distinguished only by address.
// - Arrival time kept per region; widths kept per pixel, zeros included.
// - Each pixel feeds triggered path and prompt OR, each with own mask.
// - No hit size classes; any unmasked hit raises the region hit.
// - Each pixel counts bunch clock ticks while its discriminator is high.
// - Counter stops at maximum while high; fifteen or more stored as 0xF.
// - Eight latency timers per region; eight 4-bit width registers per pixel.
// - Width register k always pairs with region timer k; no region dead time.
// - Timers are 9 bits; latency up to 511 crossings.
// - Timers idle until region hit; one new timer per crossing at most.
// - Expiry without trigger frees the timer and clears its widths.
// - Expiry with trigger keeps widths and stores a trigger tag.
// - Readout by column token chain, one trigger tag at a time.
// - Injection edge acts as digital injection into the hit chain of each pixel set in inj_enable_i.
`timescale 1ns/1ps
module prhb_core
    import prhb_pkg::*;
#(
    parameter int CORE_DELAY = 1,
    parameter int ANA_CFG_W  = 64,
    parameter int FIFO_DEPTH = PRHB_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_i,
    // Analog islands
    input  wire logic [PRHB_NPIX-1:0]  disc_i,
    input  wire logic [ANA_CFG_W-1:0]  analog_cfg_i,
    output logic      [ANA_CFG_W-1:0]  analog_cfg_o,
    // Pixel configuration
    input  wire logic [PRHB_NPIX-1:0]  pix_enable_i,
    input  wire logic [PRHB_NPIX-1:0]  prompt_or_mask_i,
    input  wire logic [PRHB_NPIX-1:0]  inj_enable_i,
    input  wire logic [PRHB_LAT_W-1:0] latency_i,
    // Column gating
    input  wire logic                  bunch_gate_i,
    input  wire logic                  cal_gate_i,
    // Global signals from the core below
    input  wire logic                  bunch_clk_i,
    input  wire logic                  cal_edge_i,
    input  wire logic                  trigger_i,
    input  wire logic [PRHB_TAG_W-1:0] trigger_tag_i,
    input  wire logic                  read_req_i,
    input  wire logic [PRHB_TAG_W-1:0] read_tag_i,
    input  wire logic                  token_in_i,
    // Regenerated for the core above
    output logic                       bunch_clk_o,
    output logic                       cal_edge_o,
    output logic                       trigger_o,
    output logic [PRHB_TAG_W-1:0]      trigger_tag_o,
    output logic                       read_req_o,
    output logic [PRHB_TAG_W-1:0]      read_tag_o,
    // Prompt path
    output logic                       prompt_or_o,
    // Readout
    output logic                       token_out_o,
    output logic [PRHB_REC_W-1:0]      hit_data_o,
    output logic                       hit_valid_o,
    input  wire logic                  hit_ready_i,
    // Status
    output logic [PRHB_NREG-1:0]       region_full_o,
    output logic                       hit_drop_o
);
    localparam int DLY = CORE_DELAY * PRHB_SKEW_CYC;
    localparam int NSLOT = PRHB_NREG * PRHB_NTIM;

    function automatic logic [PRHB_TIM_IDX_W:0] first_free(input logic [PRHB_NTIM-1:0] busy);
        logic [PRHB_TIM_IDX_W:0] res;
        res = '0;
        for (int k = PRHB_NTIM - 1; k >= 0; k--) begin
            if (!busy[k]) begin
                res = {1'b1, PRHB_TIM_IDX_W'(k)};
            end
        end
        return res;
    endfunction

    function automatic logic [PRHB_SLOT_W:0] first_set(input logic [NSLOT-1:0] vec);
        logic [PRHB_SLOT_W:0] res;
        res = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (vec[i]) begin
                res = {1'b1, PRHB_SLOT_W'(i)};
            end
        end
        return res;
    endfunction

    // Input synchronisers
    logic [PRHB_SYNC_W-1:0] sync_meta;
    logic [PRHB_SYNC_W-1:0] sync_q;
    logic [PRHB_NPIX-1:0]   disc_s;
    logic                   bunch_s;
    logic                   cal_s;
    logic                   trig_s;
    logic [PRHB_TAG_W-1:0]  trig_tag_s;
    logic                   rd_req_s;
    logic [PRHB_TAG_W-1:0]  rd_tag_s;
    logic                   token_s;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= {disc_i, bunch_clk_i, cal_edge_i, trigger_i, trigger_tag_i,
                          read_req_i, read_tag_i, token_in_i};
            sync_q    <= sync_meta;
        end
    end

    assign {disc_s, bunch_s, cal_s, trig_s, trig_tag_s, rd_req_s, rd_tag_s, token_s} = sync_q;

    // Re-drive for the next core, no extra internal delay on this path
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bunch_clk_o   <= 1'b0;
            cal_edge_o    <= 1'b0;
            trigger_o     <= 1'b0;
            trigger_tag_o <= PRHB_TAG_RST;
            read_req_o    <= 1'b0;
            read_tag_o    <= PRHB_TAG_RST;
            analog_cfg_o  <= '0;
        end else begin
            bunch_clk_o   <= bunch_s;
            cal_edge_o    <= cal_s;
            trigger_o     <= trig_s;
            trigger_tag_o <= trig_tag_s;
            read_req_o    <= rd_req_s;
            read_tag_o    <= rd_tag_s;
            analog_cfg_o  <= analog_cfg_i;
        end
    end

    // Internal copy of clock edge and injection, delayed to align across the column
    logic             bunch_prev;
    logic [DLY-1:0]   rise_dly;
    logic [DLY-1:0]   cal_dly;
    logic             bunch_tick;
    logic             cal_lvl;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bunch_prev <= 1'b0;
            rise_dly   <= '0;
            cal_dly    <= '0;
        end else begin
            bunch_prev <= bunch_s;
            rise_dly   <= DLY'({rise_dly, bunch_s & ~bunch_prev});
            cal_dly    <= DLY'({cal_dly, cal_s});
        end
    end

    assign bunch_tick = rise_dly[DLY-1] & bunch_gate_i;
    assign cal_lvl    = cal_dly[DLY-1] & cal_gate_i;

    // Prompt OR path, separate mask from the triggered path
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prompt_or_o <= 1'b0;
        end else begin
            prompt_or_o <= |(disc_s & prompt_or_mask_i);
        end
    end

    // Pixel hit chain state
    logic [PRHB_NPIX-1:0]      hit_lvl;
    logic [PRHB_NPIX-1:0]      lead;
    logic [PRHB_NPIX-1:0]      counting;
    logic [PRHB_NPIX-1:0]      sat_wait;
    logic [PRHB_NPIX-1:0]      slot_ok;
    logic [PRHB_TIM_IDX_W-1:0] slot [PRHB_NPIX];
    logic [PRHB_WID_W-1:0]     cnt [PRHB_NPIX];
    logic [PRHB_NPIX-1:0]      wr_en;
    logic [PRHB_WID_W-1:0]     wr_val [PRHB_NPIX];
    logic [PRHB_WID_W-1:0]     wmem [PRHB_NPIX][PRHB_NTIM];

    // Region timer state
    logic [PRHB_NTIM-1:0]      t_busy [PRHB_NREG];
    logic [PRHB_NTIM-1:0]      t_tagged [PRHB_NREG];
    logic [PRHB_LAT_W-1:0]     t_cnt [PRHB_NREG][PRHB_NTIM];
    logic [PRHB_TAG_W-1:0]     t_tag [PRHB_NREG][PRHB_NTIM];
    logic [PRHB_NREG-1:0]      region_lead;
    logic [PRHB_TIM_IDX_W:0]   free [PRHB_NREG];
    logic [PRHB_NTIM-1:0]      expire [PRHB_NREG];
    logic [PRHB_NTIM-1:0]      clr [PRHB_NREG];

    // Readout
    prhb_rd_state_type         rd_state;
    logic [NSLOT-1:0]          match;
    logic [PRHB_SLOT_W:0]      pick;
    logic                      fifo_in_ready;
    logic                      fifo_out_valid;
    logic                      push;
    logic [PRHB_REG_IDX_W-1:0] pick_reg;
    logic [PRHB_TIM_IDX_W-1:0] pick_tim;
    logic [PRHB_REC_W-1:0]     rec;

    assign hit_lvl = (disc_s & pix_enable_i) | ({PRHB_NPIX{cal_lvl}} & inj_enable_i);
    assign lead    = {PRHB_NPIX{bunch_tick}} & hit_lvl & ~counting & ~sat_wait;

    always_comb begin
        for (int r = 0; r < PRHB_NREG; r++) begin
            region_lead[r] = |lead[r*PRHB_RPIX +: PRHB_RPIX];
            free[r]        = first_free(t_busy[r]);
            for (int k = 0; k < PRHB_NTIM; k++) begin
                expire[r][k] = bunch_tick & t_busy[r][k] & ~t_tagged[r][k]
                               & (t_cnt[r][k] == latency_i);
                clr[r][k]    = (expire[r][k] & ~trig_s)
                               | (push && pick_reg == PRHB_REG_IDX_W'(r)
                                  && pick_tim == PRHB_TIM_IDX_W'(k));
            end
        end
    end

    // Width counting ends on falling discriminator or saturation
    always_comb begin
        for (int p = 0; p < PRHB_NPIX; p++) begin
            wr_en[p]  = 1'b0;
            wr_val[p] = cnt[p];
            if (bunch_tick && counting[p]) begin
                if (!hit_lvl[p]) begin
                    wr_en[p] = 1'b1;
                end else if (cnt[p] == PRHB_WID_MAX - PRHB_WID_ONE) begin
                    wr_en[p]  = 1'b1;
                    wr_val[p] = PRHB_WID_MAX;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            counting <= '0;
            sat_wait <= '0;
            slot_ok  <= '0;
            for (int p = 0; p < PRHB_NPIX; p++) begin
                cnt[p]  <= PRHB_WID_RST;
                slot[p] <= '0;
            end
        end else begin
            for (int p = 0; p < PRHB_NPIX; p++) begin
                if (lead[p]) begin
                    counting[p] <= 1'b1;
                    cnt[p]      <= PRHB_WID_ONE;
                    slot[p]     <= free[p / PRHB_RPIX][PRHB_TIM_IDX_W-1:0];
                    slot_ok[p]  <= free[p / PRHB_RPIX][PRHB_TIM_IDX_W];
                end else if (wr_en[p]) begin
                    counting[p] <= 1'b0;
                    sat_wait[p] <= hit_lvl[p];
                end else if (bunch_tick && counting[p]) begin
                    cnt[p] <= cnt[p] + PRHB_WID_ONE;
                end else if (bunch_tick && !hit_lvl[p]) begin
                    sat_wait[p] <= 1'b0;
                end
            end
        end
    end

    // Timers: start on region hit, expire at programmed latency
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int r = 0; r < PRHB_NREG; r++) begin
                t_busy[r]   <= '0;
                t_tagged[r] <= '0;
                for (int k = 0; k < PRHB_NTIM; k++) begin
                    t_cnt[r][k] <= PRHB_LAT_RST;
                    t_tag[r][k] <= PRHB_TAG_RST;
                end
            end
        end else begin
            for (int r = 0; r < PRHB_NREG; r++) begin
                for (int k = 0; k < PRHB_NTIM; k++) begin
                    if (region_lead[r] && free[r][PRHB_TIM_IDX_W]
                        && free[r][PRHB_TIM_IDX_W-1:0] == PRHB_TIM_IDX_W'(k)) begin
                        t_busy[r][k] <= 1'b1;
                        t_cnt[r][k]  <= PRHB_LAT_RST;
                    end else if (clr[r][k]) begin
                        t_busy[r][k]   <= 1'b0;
                        t_tagged[r][k] <= 1'b0;
                    end else if (expire[r][k]) begin
                        t_tagged[r][k] <= 1'b1;
                        t_tag[r][k]    <= trig_tag_s;
                    end else if (bunch_tick && t_busy[r][k] && !t_tagged[r][k]) begin
                        t_cnt[r][k] <= t_cnt[r][k] + PRHB_LAT_ONE;
                    end
                end
            end
        end
    end

    // Width storage: cleared at timer start, on expiry without trigger and after readout
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < PRHB_NPIX; p++) begin
                for (int k = 0; k < PRHB_NTIM; k++) begin
                    wmem[p][k] <= PRHB_WID_RST;
                end
            end
        end else begin
            for (int p = 0; p < PRHB_NPIX; p++) begin
                for (int k = 0; k < PRHB_NTIM; k++) begin
                    if (region_lead[p / PRHB_RPIX] && free[p / PRHB_RPIX][PRHB_TIM_IDX_W]
                        && free[p / PRHB_RPIX][PRHB_TIM_IDX_W-1:0] == PRHB_TIM_IDX_W'(k)) begin
                        wmem[p][k] <= PRHB_WID_RST;
                    end else if (clr[p / PRHB_RPIX][k]) begin
                        wmem[p][k] <= PRHB_WID_RST;
                    end else if (wr_en[p] && slot_ok[p] && slot[p] == PRHB_TIM_IDX_W'(k)
                                 && t_busy[p / PRHB_RPIX][k]) begin
                        wmem[p][k] <= wr_val[p];
                    end
                end
            end
        end
    end

    // Token chain readout of the requested tag
    always_comb begin
        for (int r = 0; r < PRHB_NREG; r++) begin
            for (int k = 0; k < PRHB_NTIM; k++) begin
                match[r*PRHB_NTIM + k] = t_busy[r][k] & t_tagged[r][k]
                                         & (t_tag[r][k] == rd_tag_s);
            end
        end
    end

    assign pick     = first_set(match);
    assign pick_reg = pick[PRHB_SLOT_W-1:PRHB_TIM_IDX_W];
    assign pick_tim = pick[PRHB_TIM_IDX_W-1:0];
    assign push     = (rd_state == PRHB_RD_SCAN) && rd_req_s && pick[PRHB_SLOT_W]
                      && fifo_in_ready;

    always_comb begin
        rec = {pick_reg, rd_tag_s, {PRHB_RPIX*PRHB_WID_W{1'b0}}};
        for (int i = 0; i < PRHB_RPIX; i++) begin
            rec[i*PRHB_WID_W +: PRHB_WID_W] = wmem[pick_reg*PRHB_RPIX + i][pick_tim];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_state <= PRHB_RD_IDLE;
        end else begin
            case (rd_state)
                PRHB_RD_IDLE: begin
                    if (token_s && rd_req_s) begin
                        rd_state <= PRHB_RD_SCAN;
                    end
                end
                PRHB_RD_SCAN: begin
                    if (!rd_req_s) begin
                        rd_state <= PRHB_RD_IDLE;
                    end else if (!pick[PRHB_SLOT_W] && !fifo_out_valid) begin
                        rd_state <= PRHB_RD_PASS;
                    end
                end
                PRHB_RD_PASS: begin
                    if (!rd_req_s) begin
                        rd_state <= PRHB_RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= PRHB_RD_IDLE;
                end
            endcase
        end
    end

    assign token_out_o = (rd_state == PRHB_RD_PASS) && token_s;

    // Status
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            region_full_o <= '0;
            hit_drop_o    <= 1'b0;
        end else begin
            hit_drop_o <= 1'b0;
            for (int r = 0; r < PRHB_NREG; r++) begin
                region_full_o[r] <= &t_busy[r];
                if (region_lead[r] && !free[r][PRHB_TIM_IDX_W]) begin
                    hit_drop_o <= 1'b1;
                end
            end
        end
    end

    prhb_fifo #(
        .WIDTH (PRHB_REC_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (rec),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (hit_ready_i),
        .out_data_o  (hit_data_o)
    );

    assign hit_valid_o = fifo_out_valid;

endmodule

/* File: prhb_checker.sv */
// Port assertions for the pixel region hit buffer core.
// Assumes bind onto prhb_core; one clock, synchronous reset.
`timescale 1ns/1ps
module prhb_checker
    import prhb_pkg::*;
#(
    parameter int ANA_CFG_W = 64
) (
    // Clock, reset, inputs
    input wire logic                 core_clk_i,
    input wire logic                 rst_i,
    input wire logic [PRHB_NPIX-1:0] disc_i,
    input wire logic [PRHB_NPIX-1:0] prompt_or_mask_i,
    input wire logic [ANA_CFG_W-1:0] analog_cfg_i,
    input wire logic                 trigger_i,
    input wire logic                 token_in_i,
    input wire logic                 hit_ready_i,
    // Outputs watched
    input wire logic [ANA_CFG_W-1:0] analog_cfg_o,
    input wire logic                 trigger_o,
    input wire logic                 prompt_or_o,
    input wire logic                 token_out_o,
    input wire logic                 hit_valid_o,
    input wire logic [PRHB_REC_W-1:0] hit_data_o,
    input wire logic [PRHB_NREG-1:0] region_full_o,
    input wire logic                 hit_drop_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Past values before release are meaningless
    logic [2:0] age;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    cfg_copy_a: assert property (age != 3'h0 |-> analog_cfg_o == $past(analog_cfg_i))
        else $error("island config copy wrong");
    trig_redrive_a: assert property (age > 3'h3 |-> trigger_o == $past(trigger_i, 3))
        else $error("trigger re-drive wrong");
    prompt_or_a: assert property (age > 3'h3 |->
        prompt_or_o == |($past(disc_i, 3) & $past(prompt_or_mask_i)))
        else $error("prompt OR wrong");
    drop_full_a: assert property (hit_drop_o |-> |region_full_o || $past(|region_full_o))
        else $error("drop without full region");
    drop_pulse_a: assert property (hit_drop_o |=> !hit_drop_o)
        else $error("drop pulse too long");
    token_drained_a: assert property (token_out_o |-> !hit_valid_o)
        else $error("token passed with data");
    token_source_a: assert property (age > 3'h1 |-> token_out_o |-> $past(token_in_i, 2))
        else $error("token without token in");
    record_hold_a: assert property (hit_valid_o && !hit_ready_i |=>
        hit_valid_o && $stable(hit_data_o))
        else $error("record not held");
endmodule
bind prhb_core prhb_checker #(.ANA_CFG_W(ANA_CFG_W)) CHK (.core_clk_i, .rst_i, .disc_i,
    .prompt_or_mask_i, .analog_cfg_i, .trigger_i, .token_in_i, .hit_ready_i, .analog_cfg_o,
    .trigger_o, .prompt_or_o, .token_out_o, .hit_valid_o, .hit_data_o, .region_full_o,
    .hit_drop_o);

/* File: prhb_far_model.sv */
// Far side: free-running bunch clock and a readout sink that can stall.
// Assumes the sink shares core_clk_i with the core.
`timescale 1ns/1ps
module prhb_far_model
    import prhb_pkg::*;
(
    // Clock
    input  wire logic                  core_clk_i,
    output logic                       bunch_clk_o,
    // Readout sink
    input  wire logic                  hit_valid_i,
    input  wire logic [PRHB_REC_W-1:0] hit_data_i,
    input  wire logic                  stall_i,
    output logic                       hit_ready_o
);
    logic [PRHB_REC_W-1:0] got_q[$];
    logic [1:0]            phase = 2'h0;
    initial begin
        bunch_clk_o = 1'b0;
        hit_ready_o = 1'b0;
    end
    // Never stops: the matrix needs it running from start-up
    always #12.5 bunch_clk_o = ~bunch_clk_o;
    // Slow mode takes one beat in four
    always @(negedge core_clk_i) begin
        phase       <= phase + 2'h1;
        hit_ready_o <= !stall_i || (phase == 2'h3);
    end
    always @(posedge core_clk_i) begin
        if (hit_valid_i && hit_ready_o) got_q.push_back(hit_data_i);
    end
endmodule

/* File: pixel_region_hit_buffer_tb.sv */
// Testbench: hits, latency expiry with and without trigger, overflow, prompt OR.
// Assumes prhb_core defaults and the far model for bunch clock and sink.
`timescale 1ns/1ps
module pixel_region_hit_buffer_tb;
    import prhb_pkg::*;
    logic core_clk_i = 1'b0, rst_i = 1'b1, trigger_i = 1'b0, read_req_i = 1'b0;
    logic token_in_i = 1'b0, stall = 1'b0, bunch_clk_i, hit_ready_i, trigger_o, prompt_or_o;
    logic [63:0] disc_i = 64'h0, pix_enable_i = 64'hFFFF_FFFF_FFFF_FFDF;
    logic [63:0] prompt_or_mask_i = 64'h3, analog_cfg_i = 64'h1234_5678_9ABC_DEF0, analog_cfg_o;
    logic [8:0]  latency_i = 9'h014;
    logic [4:0]  trigger_tag_i = 5'h03, read_tag_i = 5'h00, trigger_tag_o, read_tag_o;
    logic cal_edge_i = 1'b0, bunch_gate_i = 1'b1, cal_edge_o, read_req_o;
    logic [63:0] inj_enable_i = 64'h0000_0000_0000_1000;
    logic [24:0] hit_data_o;
    logic [15:0] region_full_o;
    logic        hit_valid_o, token_out_o, hit_drop_o, full_seen = 1'b0;
    int          errors = 0, n_compared = 0, drops = 0, cyc = 0;
    always #2 core_clk_i = ~core_clk_i;
    prhb_core DUT (.core_clk_i, .rst_i, .disc_i, .analog_cfg_i, .analog_cfg_o, .pix_enable_i,
        .prompt_or_mask_i, .inj_enable_i, .latency_i, .bunch_gate_i,
        .cal_gate_i(1'b1), .bunch_clk_i, .cal_edge_i, .trigger_i, .trigger_tag_i,
        .read_req_i, .read_tag_i, .token_in_i, .bunch_clk_o(), .cal_edge_o, .trigger_o,
        .trigger_tag_o, .read_req_o, .read_tag_o, .prompt_or_o, .token_out_o,
        .hit_data_o, .hit_valid_o, .hit_ready_i, .region_full_o, .hit_drop_o);
    prhb_far_model PM (.core_clk_i, .bunch_clk_o(bunch_clk_i), .hit_valid_i(hit_valid_o),
        .hit_data_i(hit_data_o), .stall_i(stall), .hit_ready_o(hit_ready_i));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (hit_drop_o === 1'b1) drops++;
        if (region_full_o[3] === 1'b1) full_seen = 1'b1;
        if (cyc == 6000) begin
            errors++;
            final_report();
        end
    end
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_val({63'h0, got}, {63'h0, exp});
    endtask
    // Disc changes mid-period so every tick sees a settled level
    task automatic ticks(input int n);
        repeat (n) @(negedge bunch_clk_i);
        @(negedge core_clk_i);
    endtask
    task automatic read_out(input logic [4:0] tag, input int n);
        read_tag_i = tag;
        read_req_i = 1'b1;
        token_in_i = 1'b1;
        for (int i = 0; i < 800 && token_out_o !== 1'b1; i++) @(negedge core_clk_i);
        check_bit(token_out_o, 1'b1);
        check_bit(read_req_o, 1'b1);
        check_val(64'(read_tag_o), 64'(tag));
        check_val(64'(PM.got_q.size()), 64'(n));
        read_req_i = 1'b0;
        token_in_i = 1'b0;
        repeat (8) @(negedge core_clk_i);
    endtask
    initial begin
        repeat (16) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        check_val(analog_cfg_o, analog_cfg_i);
        check_bit(token_out_o, 1'b0);
        trigger_i = 1'b1;
        ticks(1);
        disc_i = 64'h0000_0000_0000_0074;
        ticks(3);
        disc_i = 64'h0000_0000_0000_0064;
        ticks(2);
        disc_i = 64'h0000_0000_0000_0004;
        ticks(12);
        disc_i = 64'h0;
        ticks(8);
        check_bit(trigger_o, 1'b1);
        check_val(64'(trigger_tag_o), 64'h3);
        trigger_i = 1'b0;
        stall = 1'b1;
        read_out(5'h03, 2);
        check_val(64'(PM.got_q.pop_front()), 64'({4'h0, 5'h03, 16'h0F00}));
        check_val(64'(PM.got_q.pop_front()), 64'({4'h1, 5'h03, 16'h0503}));
        $display("test triggered hits done");
        disc_i = 64'h0000_0000_0000_0100;
        ticks(2);
        disc_i = 64'h0;
        ticks(25);
        read_out(5'h03, 0);
        $display("test untriggered expiry done");
        ticks(1);
        repeat (9) begin
            cal_edge_i = 1'b1;
            ticks(1);
            check_bit(cal_edge_o, 1'b1);
            cal_edge_i = 1'b0;
            ticks(1);
        end
        check_val(64'(drops), 64'h1);
        check_bit(full_seen, 1'b1);
        bunch_gate_i = 1'b0;
        ticks(25);
        check_bit(region_full_o[3], 1'b1);
        bunch_gate_i = 1'b1;
        ticks(25);
        check_bit(region_full_o[3], 1'b0);
        $display("test timer overflow done");
        pix_enable_i = 64'h0;
        prompt_or_mask_i = 64'h1;
        disc_i = 64'h0000_0000_0000_0002;
        repeat (6) @(negedge core_clk_i);
        check_bit(prompt_or_o, 1'b0);
        disc_i = 64'h0000_0000_0000_0001;
        repeat (6) @(negedge core_clk_i);
        check_bit(prompt_or_o, 1'b1);
        $display("test prompt path done");
        final_report();
    end
endmodule
